// ==== design/edr_dev.sv ====
// Purpose: drive end, decodes and runs DMA read ext and log read ext
// Assumes: media port answers one word per md_valid while md_ready is high
// Notes: both commands move their words over the DMA handshake
`timescale 1ns/1ps
module edr_dev #(
  parameter int WPS = edr_pkg::EDR_WORDS_PER_SECTOR
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Link to host adapter
  edr_if.dev lnk,
  // Feature set enables
  input wire logic smart_en,
  // Media and log store
  output logic md_req,
  output logic md_log,
  output logic [7:0] md_log_addr,
  output logic [47:0] md_addr,
  output logic md_ready,
  input wire logic md_valid,
  input wire logic [15:0] md_data,
  input wire logic md_err
);
  import edr_pkg::*;

  typedef enum logic [2:0] {
    EDR_IDLE, EDR_CHECK, EDR_REQ, EDR_WORD, EDR_SEND
  } edr_state_t;

  edr_state_t state_r;
  logic [7:0] prev_r [EDR_TF_NREG];
  logic [7:0] cur_r [EDR_TF_NREG];
  logic [47:0] lba_r;
  logic [16:0] sec_left_r;
  logic [8:0] word_cnt_r;
  logic [7:0] log_addr_r;
  logic is_log_r;
  logic dmarq_r;
  logic [15:0] word_r;
  logic intrq_r;
  logic [7:0] status_r;
  logic [7:0] error_r;
  logic md_req_r;
  logic md_ready_r;
  logic cmd_wr;
  logic log_ok;
  logic [15:0] log_size;
  logic [15:0] req_count;
  logic [15:0] log_offset;

  function automatic logic [7:0] mk_status(input logic bsy, input logic drq,
                                           input logic err);
    logic [7:0] s;
    s = '0;
    s[EDR_ST_BSY] = bsy;
    s[EDR_ST_DRDY] = 1'b1;
    s[EDR_ST_DRQ] = drq;
    s[EDR_ST_ERR] = err;
    return s;
  endfunction

  function automatic logic [7:0] mk_error(input logic unc, input logic abrt);
    logic [7:0] e;
    e = '0;
    e[EDR_ER_UNC] = unc;
    e[EDR_ER_ABRT] = abrt;
    return e;
  endfunction

  assign cmd_wr = lnk.tf_wr && lnk.tf_sel == EDR_TF_CMD;
  // Count and offset, earlier write is the upper byte
  assign req_count = {prev_r[EDR_TF_COUNT], cur_r[EDR_TF_COUNT]};
  assign log_offset = {prev_r[EDR_TF_MID], cur_r[EDR_TF_MID]};

  // ==========================================================
  // Log decode
  edr_log_map u_map (
    .log_addr(cur_r[EDR_TF_LOW]),
    .smart_en(smart_en),
    .log_ok(log_ok),
    .log_size(log_size)
  );

  // ==========================================================
  // Task file: each feature to high register write while idle pushes current byte into previous
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < EDR_TF_NREG; i++) begin
        prev_r[i] <= '0;
        cur_r[i] <= '0;
      end
    end else if (lnk.tf_wr && lnk.tf_sel < EDR_TF_CMD && state_r == EDR_IDLE) begin
      for (int i = 0; i < EDR_TF_NREG; i++) begin
        if (lnk.tf_sel == 3'(i)) begin
          prev_r[i] <= cur_r[i];
          cur_r[i] <= lnk.tf_data;
        end
      end
    end
  end

  // ==========================================================
  // Command engine
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= EDR_IDLE;
      lba_r <= '0;
      sec_left_r <= '0;
      word_cnt_r <= '0;
      log_addr_r <= '0;
      is_log_r <= 1'b0;
      dmarq_r <= 1'b0;
      word_r <= '0;
      intrq_r <= 1'b0;
      status_r <= EDR_ST_RESET;
      error_r <= '0;
      md_req_r <= 1'b0;
      md_ready_r <= 1'b0;
    end else begin
      md_req_r <= 1'b0;
      unique case (state_r)
        EDR_IDLE: begin
          if (cmd_wr) begin
            intrq_r <= 1'b0;
            error_r <= '0;
            if (lnk.tf_data == EDR_CMD_DMA_EXT) begin
              lba_r <= {prev_r[EDR_TF_HIGH], prev_r[EDR_TF_MID], prev_r[EDR_TF_LOW],
                        cur_r[EDR_TF_HIGH], cur_r[EDR_TF_MID], cur_r[EDR_TF_LOW]};
              sec_left_r <= (req_count == '0) ? EDR_COUNT_ZERO_SECTORS
                                              : {1'b0, req_count};
              is_log_r <= 1'b0;
              status_r <= mk_status(1'b1, 1'b0, 1'b0);
              state_r <= EDR_REQ;
            end else if (lnk.tf_data == EDR_CMD_LOG_EXT) begin
              is_log_r <= 1'b1;
              status_r <= mk_status(1'b1, 1'b0, 1'b0);
              state_r <= EDR_CHECK;
            end else begin
              // Unknown code, abort from check so interrupt rises anew
              is_log_r <= 1'b0;
              status_r <= mk_status(1'b1, 1'b0, 1'b0);
              state_r <= EDR_CHECK;
            end
          end
        end
        EDR_CHECK: begin
          if (!is_log_r || !log_ok || cur_r[EDR_TF_FEAT] != '0 || prev_r[EDR_TF_FEAT] != '0 ||
              cur_r[EDR_TF_HIGH] != '0 || prev_r[EDR_TF_HIGH] != '0 ||
              req_count == '0 || log_offset >= log_size) begin
            status_r <= mk_status(1'b0, 1'b0, 1'b1);
            error_r <= mk_error(1'b0, 1'b1);
            intrq_r <= 1'b1;
            state_r <= EDR_IDLE;
          end else begin
            log_addr_r <= cur_r[EDR_TF_LOW];
            lba_r <= {32'h0000_0000, log_offset};
            sec_left_r <= {1'b0, req_count};
            state_r <= EDR_REQ;
          end
        end
        EDR_REQ: begin
          md_req_r <= 1'b1;
          md_ready_r <= 1'b1;
          word_cnt_r <= '0;
          state_r <= EDR_WORD;
        end
        EDR_WORD: begin
          if (md_valid && md_ready_r) begin
            md_ready_r <= 1'b0;
            if (md_err) begin
              // Address stays on the failing sector
              status_r <= mk_status(1'b0, 1'b0, 1'b1);
              error_r <= mk_error(1'b1, 1'b0);
              intrq_r <= 1'b1;
              state_r <= EDR_IDLE;
            end else begin
              word_r <= md_data;
              dmarq_r <= 1'b1;
              status_r <= mk_status(1'b1, 1'b1, 1'b0);
              state_r <= EDR_SEND;
            end
          end
        end
        EDR_SEND: begin
          if (lnk.dmack) begin
            dmarq_r <= 1'b0;
            if (word_cnt_r == 9'(WPS - 1)) begin
              sec_left_r <= sec_left_r - 17'h0_0001;
              if (sec_left_r == 17'h0_0001) begin
                status_r <= mk_status(1'b0, 1'b0, 1'b0);
                intrq_r <= 1'b1;
                state_r <= EDR_IDLE;
              end else begin
                lba_r <= lba_r + 48'h0000_0000_0001;
                status_r <= mk_status(1'b1, 1'b0, 1'b0);
                state_r <= EDR_REQ;
              end
            end else begin
              word_cnt_r <= word_cnt_r + 9'h001;
              md_ready_r <= 1'b1;
              status_r <= mk_status(1'b1, 1'b0, 1'b0);
              state_r <= EDR_WORD;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign lnk.dmarq = dmarq_r;
  assign lnk.dma_data = word_r;
  assign lnk.intrq = intrq_r;
  assign lnk.status = status_r;
  assign lnk.error = error_r;
  assign lnk.lba = lba_r;
  assign md_req = md_req_r;
  assign md_log = is_log_r;
  assign md_log_addr = log_addr_r;
  assign md_addr = lba_r;
  assign md_ready = md_ready_r;
endmodule

// ==== design/edr_pkg.sv ====
// Functional notes
// - Code 25h runs the 48-bit DMA sector read
// - Address: earlier writes high byte, later low
// - Sector count 16 bits, earlier write upper
// - Host arms DMA channel before command write
// - Each word moves only under DMARQ handshake
// - One interrupt per command, after valid status
// - On error stop, address shows failing sector
// - Abort on unsupported log or bad fields
// - Log address from later low write only
// - Mid writes form 16-bit first sector offset
// - Transfer starts at offset, runs requested count
// - Log 00h is one-sector read-only directory
// - Log 03h 64 sectors, 23h 96 sectors
// - Log 07h is one-sector self-test log
// - Logs 01h, 02h, 06h abort here
// - Log 09h is one-sector selective self-test log
// - Host avoids device-vendor logs A0h-BFh
//
// Purpose: shared constants for the extended DMA read and log read engine
// Assumes: one 200 MHz clock, task file written one byte per strobe
// Notes: sector payload is moved as 16-bit words
package edr_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] EDR_CMD_DMA_EXT = 8'h25;
  localparam logic [7:0] EDR_CMD_LOG_EXT = 8'h2F;
  // ==========================================================
  // Task file select codes
  localparam logic [2:0] EDR_TF_FEAT = 3'h0;
  localparam logic [2:0] EDR_TF_COUNT = 3'h1;
  localparam logic [2:0] EDR_TF_LOW = 3'h2;
  localparam logic [2:0] EDR_TF_MID = 3'h3;
  localparam logic [2:0] EDR_TF_HIGH = 3'h4;
  localparam logic [2:0] EDR_TF_CMD = 3'h7;
  localparam int EDR_TF_NREG = 5;
  // ==========================================================
  // Status and error bit positions
  localparam int EDR_ST_BSY = 7;
  localparam int EDR_ST_DRDY = 6;
  localparam int EDR_ST_DRQ = 3;
  localparam int EDR_ST_ERR = 0;
  localparam int EDR_ER_UNC = 6;
  localparam int EDR_ER_ABRT = 2;
  localparam logic [7:0] EDR_ST_RESET = 8'h40;
  // ==========================================================
  // Sector geometry
  localparam int EDR_WORDS_PER_SECTOR = 256;
  localparam logic [16:0] EDR_COUNT_ZERO_SECTORS = 17'h1_0000;
  // ==========================================================
  // Log addresses and sizes in sectors
  localparam logic [7:0] EDR_LOG_DIR = 8'h00;
  localparam logic [7:0] EDR_LOG_SUM = 8'h01;
  localparam logic [7:0] EDR_LOG_COMP = 8'h02;
  localparam logic [7:0] EDR_LOG_XERR = 8'h03;
  localparam logic [7:0] EDR_LOG_STEST = 8'h06;
  localparam logic [7:0] EDR_LOG_XSTEST = 8'h07;
  localparam logic [7:0] EDR_LOG_SEL = 8'h09;
  localparam logic [7:0] EDR_LOG_DELAY = 8'h23;
  localparam logic [7:0] EDR_LOG_HV_LO = 8'h80;
  localparam logic [7:0] EDR_LOG_HV_HI = 8'h9F;
  localparam logic [7:0] EDR_LOG_DV_ONE = 8'hA0;
  localparam logic [7:0] EDR_LOG_DV_BIG_LO = 8'hA1;
  localparam logic [7:0] EDR_LOG_DV_BIG_HI = 8'hA2;
  localparam logic [7:0] EDR_LOG_DV_RW_LO = 8'hA3;
  localparam logic [7:0] EDR_LOG_DV_RW_HI = 8'hBF;
  localparam logic [15:0] EDR_SZ_ONE = 16'h0001;
  localparam logic [15:0] EDR_SZ_XERR = 16'h0040;
  localparam logic [15:0] EDR_SZ_BIG = 16'h0060;
  localparam logic [15:0] EDR_SZ_HOSTV = 16'h0010;
  // ==========================================================
  // Host write sequence last index (ten writes, 0 to 9)
  localparam logic [3:0] EDR_SEQ_LAST = 4'h9;
endpackage

// ==== design/edr_if.sv ====
// Purpose: task file and DMA link between host adapter and drive
// Assumes: both ends on sys_clk
// Notes: dmarq/dmack form a one-word request handshake
`timescale 1ns/1ps
interface edr_if;
  logic tf_wr;
  logic [2:0] tf_sel;
  logic [7:0] tf_data;
  logic dmack;
  logic dmarq;
  logic [15:0] dma_data;
  logic intrq;
  logic [7:0] status;
  logic [7:0] error;
  logic [47:0] lba;
  modport dev (
    input tf_wr, tf_sel, tf_data, dmack,
    output dmarq, dma_data, intrq, status, error, lba
  );
  modport host (
    output tf_wr, tf_sel, tf_data, dmack,
    input dmarq, dma_data, intrq, status, error, lba
  );
endinterface

// ==== design/edr_log_map.sv ====
// Purpose: log address decode for the extended log read
// Assumes: combinational, used by the drive end
// Notes: size is zero for logs refused by this command
`timescale 1ns/1ps
module edr_log_map (
  // Selection
  input wire logic [7:0] log_addr,
  input wire logic smart_en,
  // Result
  output logic log_ok,
  output logic [15:0] log_size
);
  import edr_pkg::*;

  always_comb begin
    log_ok = 1'b0;
    log_size = EDR_SZ_ONE;
    if (log_addr == EDR_LOG_DIR) begin
      log_ok = 1'b1;
    end else if (log_addr == EDR_LOG_SUM || log_addr == EDR_LOG_COMP ||
                 log_addr == EDR_LOG_STEST) begin
      log_ok = 1'b0;
    end else if (log_addr == EDR_LOG_XERR) begin
      log_ok = smart_en;
      log_size = EDR_SZ_XERR;
    end else if (log_addr == EDR_LOG_DELAY) begin
      log_ok = smart_en;
      log_size = EDR_SZ_BIG;
    end else if (log_addr == EDR_LOG_XSTEST) begin
      log_ok = smart_en;
    end else if (log_addr == EDR_LOG_SEL) begin
      log_ok = smart_en;
    end else if (log_addr >= EDR_LOG_HV_LO && log_addr <= EDR_LOG_HV_HI) begin
      log_ok = 1'b1;
      log_size = EDR_SZ_HOSTV;
    end else if (log_addr == EDR_LOG_DV_ONE) begin
      log_ok = 1'b1;
    end else if (log_addr >= EDR_LOG_DV_BIG_LO && log_addr <= EDR_LOG_DV_BIG_HI) begin
      log_ok = 1'b1;
      log_size = EDR_SZ_BIG;
    end else if (log_addr >= EDR_LOG_DV_RW_LO && log_addr <= EDR_LOG_DV_RW_HI) begin
      log_ok = 1'b1;
    end
    if (!log_ok) begin
      log_size = '0;
    end
  end
endmodule

// ==== design/edr_host.sv ====
// Purpose: host adapter end, loads the task file and drains DMA words
// Assumes: user holds command fields stable while cmd_start is seen
// Notes: registers are written previous then current, command last
`timescale 1ns/1ps
module edr_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Link to drive
  edr_if.host lnk,
  // Command request
  input wire logic cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic [47:0] cmd_lba,
  input wire logic [15:0] cmd_count,
  input wire logic [15:0] cmd_feat,
  output logic cmd_ready,
  // Received words
  output logic rx_valid,
  output logic [15:0] rx_data,
  // Completion
  output logic done,
  output logic [7:0] done_status,
  output logic [7:0] done_error,
  output logic [47:0] done_lba
);
  import edr_pkg::*;

  typedef enum logic [2:0] {
    EDR_H_IDLE, EDR_H_WR, EDR_H_CMD, EDR_H_SETTLE, EDR_H_WAIT
  } edr_hstate_t;

  edr_hstate_t state_r;
  logic [3:0] idx_r;
  logic [7:0] code_r;
  logic [47:0] lba_r;
  logic [15:0] count_r;
  logic [15:0] feat_r;
  logic tf_wr_r;
  logic [2:0] tf_sel_r;
  logic [7:0] tf_data_r;
  logic dmack_r;
  logic dma_en_r;
  logic rx_valid_r;
  logic [15:0] rx_data_r;
  logic done_r;
  logic [7:0] done_status_r;
  logic [7:0] done_error_r;
  logic [47:0] done_lba_r;
  logic cmd_ready_r;

  // Write order: feat, count, low, mid, high; each previous then current
  function automatic logic [10:0] seq_item(input logic [3:0] idx, input logic [47:0] a,
                                           input logic [15:0] c, input logic [15:0] f);
    logic [10:0] r;
    r = {EDR_TF_FEAT, f[15:8]};
    unique case (idx)
      4'h0: r = {EDR_TF_FEAT, f[15:8]};
      4'h1: r = {EDR_TF_FEAT, f[7:0]};
      4'h2: r = {EDR_TF_COUNT, c[15:8]};
      4'h3: r = {EDR_TF_COUNT, c[7:0]};
      4'h4: r = {EDR_TF_LOW, a[31:24]};
      4'h5: r = {EDR_TF_LOW, a[7:0]};
      4'h6: r = {EDR_TF_MID, a[39:32]};
      4'h7: r = {EDR_TF_MID, a[15:8]};
      4'h8: r = {EDR_TF_HIGH, a[47:40]};
      4'h9: r = {EDR_TF_HIGH, a[23:16]};
      default: r = {EDR_TF_FEAT, f[15:8]};
    endcase
    return r;
  endfunction

  // ==========================================================
  // Sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= EDR_H_IDLE;
      idx_r <= '0;
      code_r <= '0;
      lba_r <= '0;
      count_r <= '0;
      feat_r <= '0;
      tf_wr_r <= 1'b0;
      tf_sel_r <= '0;
      tf_data_r <= '0;
      dma_en_r <= 1'b0;
      done_r <= 1'b0;
      done_status_r <= '0;
      done_error_r <= '0;
      done_lba_r <= '0;
      cmd_ready_r <= 1'b1;
    end else begin
      tf_wr_r <= 1'b0;
      done_r <= 1'b0;
      unique case (state_r)
        EDR_H_IDLE: begin
          if (cmd_start) begin
            code_r <= cmd_code;
            lba_r <= cmd_lba;
            count_r <= cmd_count;
            feat_r <= cmd_feat;
            idx_r <= '0;
            cmd_ready_r <= 1'b0;
            state_r <= EDR_H_WR;
          end
        end
        EDR_H_WR: begin
          tf_wr_r <= 1'b1;
          {tf_sel_r, tf_data_r} <= seq_item(idx_r, lba_r, count_r, feat_r);
          idx_r <= idx_r + 4'h1;
          if (idx_r == EDR_SEQ_LAST) begin
            dma_en_r <= 1'b1;
            state_r <= EDR_H_CMD;
          end
        end
        EDR_H_CMD: begin
          tf_wr_r <= 1'b1;
          tf_sel_r <= EDR_TF_CMD;
          tf_data_r <= code_r;
          state_r <= EDR_H_SETTLE;
        end
        EDR_H_SETTLE: begin
          state_r <= EDR_H_WAIT;
        end
        EDR_H_WAIT: begin
          if (lnk.intrq) begin
            dma_en_r <= 1'b0;
            done_r <= 1'b1;
            done_status_r <= lnk.status;
            done_error_r <= lnk.error;
            done_lba_r <= lnk.lba;
            cmd_ready_r <= 1'b1;
            state_r <= EDR_H_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // DMA channel: one acknowledge per request
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dmack_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_data_r <= '0;
    end else begin
      rx_valid_r <= 1'b0;
      dmack_r <= 1'b0;
      if (dma_en_r && lnk.dmarq && !dmack_r) begin
        dmack_r <= 1'b1;
        rx_valid_r <= 1'b1;
        rx_data_r <= lnk.dma_data;
      end
    end
  end

  assign lnk.tf_wr = tf_wr_r;
  assign lnk.tf_sel = tf_sel_r;
  assign lnk.tf_data = tf_data_r;
  assign lnk.dmack = dmack_r;
  assign cmd_ready = cmd_ready_r;
  assign rx_valid = rx_valid_r;
  assign rx_data = rx_data_r;
  assign done = done_r;
  assign done_status = done_status_r;
  assign done_error = done_error_r;
  assign done_lba = done_lba_r;
endmodule

// ==== bench/edr_checker.sv ====
// Purpose: protocol assertions on the host to drive link
// Assumes: one sys_clk domain, nrst active low
// Notes: watches interface signals only
`timescale 1ns/1ps
module edr_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Task file
  input wire logic tf_wr,
  input wire logic [2:0] tf_sel,
  input wire logic [7:0] tf_data,
  // Word handshake
  input wire logic dmack,
  input wire logic dmarq,
  input wire logic [15:0] dma_data,
  // Completion
  input wire logic intrq,
  input wire logic [7:0] status,
  input wire logic [7:0] error
);
  import edr_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Sequences
  sequence s_go;
    tf_wr && tf_sel == EDR_TF_CMD && !status[EDR_ST_BSY] &&
      (tf_data == EDR_CMD_DMA_EXT || tf_data == EDR_CMD_LOG_EXT);
  endsequence
  sequence s_take;
    dmarq && dmack;
  endsequence
  // ==========================================================
  // Assertions
  a_take_drop: assert property (s_take |=> !dmarq)
    else $error("request still high after word taken");
  a_word_hold: assert property (dmarq && !dmack |=> dmarq && $stable(dma_data))
    else $error("word changed before it was taken");
  a_ack_req: assert property (dmack |-> dmarq)
    else $error("acknowledge without request");
  a_word_wait: assert property ($rose(dmarq) |-> ##[1:4] s_take)
    else $error("word not taken in time");
  a_cmd_busy: assert property (s_go |=> status[EDR_ST_BSY] && !intrq)
    else $error("command accepted without busy");
  a_busy_quiet: assert property (status[EDR_ST_BSY] |-> !intrq)
    else $error("interrupt while busy");
  a_irq_hold: assert property (intrq && !(tf_wr && tf_sel == EDR_TF_CMD) |=> intrq)
    else $error("interrupt dropped without command");
  a_irq_valid: assert property ($rose(intrq) |-> !status[EDR_ST_BSY] && !status[EDR_ST_DRQ])
    else $error("interrupt before status valid");
  a_abort_flag: assert property ($rose(intrq) && error[EDR_ER_ABRT] |-> status[EDR_ST_ERR])
    else $error("abort without error status");
  a_unc_flag: assert property ($rose(intrq) && error[EDR_ER_UNC] |-> status[EDR_ST_ERR])
    else $error("media error without error status");
  a_rq_busy: assert property (dmarq |-> status[EDR_ST_BSY])
    else $error("word offered while idle");
endmodule

// ==== bench/test_ext_dma_read_and_log_read.sv ====
// Purpose: bench joining host end and drive end
// Assumes: media answers each md_ready with one word
// Notes: WPS shortened to 4 words per sector
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %s exp %h seen %h", nm, exp, got); end end
module test_ext_dma_read_and_log_read;
  import edr_pkg::*;
  localparam int WPS = 4;
  logic sys_clk = 0;
  logic nrst = 0;
  logic smart_en = 1;
  logic md_valid = 0;
  logic md_err = 0;
  logic [15:0] md_data = 0;
  logic cmd_start = 0;
  logic [7:0] cmd_code = 0;
  logic [47:0] cmd_lba = 0;
  logic [15:0] cmd_count = 0;
  logic [15:0] cmd_feat = 0;
  logic md_req, md_log, md_ready, cmd_ready, rx_valid, done;
  logic [7:0] md_log_addr, done_status, done_error, fl, st, er;
  logic [47:0] md_addr, done_lba, fa, dl;
  logic [15:0] rx_data, md_base;
  logic [15:0] err_at = 16'hFFFF;
  logic irq_q, got_req, flog;
  int miscompares = 0;
  int n_tests = 0;
  int n_rx, n_irq;
  edr_if lnk ();
  edr_dev #(.WPS(WPS)) u_edr_dev (.sys_clk(sys_clk), .nrst(nrst), .lnk(lnk),
    .smart_en(smart_en), .md_req(md_req), .md_log(md_log), .md_log_addr(md_log_addr),
    .md_addr(md_addr), .md_ready(md_ready), .md_valid(md_valid), .md_data(md_data),
    .md_err(md_err));
  edr_host u_edr_host (.sys_clk(sys_clk), .nrst(nrst), .lnk(lnk), .cmd_start(cmd_start),
    .cmd_code(cmd_code), .cmd_lba(cmd_lba), .cmd_count(cmd_count), .cmd_feat(cmd_feat),
    .cmd_ready(cmd_ready), .rx_valid(rx_valid), .rx_data(rx_data), .done(done),
    .done_status(done_status), .done_error(done_error), .done_lba(done_lba));
  edr_checker u_edr_checker (.sys_clk(sys_clk), .nrst(nrst), .tf_wr(lnk.tf_wr),
    .tf_sel(lnk.tf_sel), .tf_data(lnk.tf_data), .dmack(lnk.dmack), .dmarq(lnk.dmarq),
    .dma_data(lnk.dma_data), .intrq(lnk.intrq), .status(lnk.status), .error(lnk.error));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Media side: one word per ready, error on word err_at
  always @(negedge sys_clk) begin
    md_valid <= md_ready && !md_valid;
    md_err <= md_ready && !md_valid && md_data == err_at;
    if (md_valid) begin
      md_data <= md_data + 16'h0001;
    end
  end
  // ==========================================================
  // Monitors
  always @(posedge sys_clk) begin
    irq_q <= lnk.intrq;
    if (lnk.intrq && !irq_q) n_irq++;
    if (rx_valid) begin
      `CHK("rx word", md_base + 16'(n_rx), rx_data)
      n_rx++;
    end
    if (md_req && !got_req) begin
      fa <= md_addr;
      fl <= md_log_addr;
      flog <= md_log;
      got_req <= 1'b1;
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic run(input logic [7:0] c, input logic [47:0] a, input logic [15:0] n,
                     input logic [15:0] f);
    int k;
    @(negedge sys_clk);
    n_rx = 0;
    n_irq = 0;
    got_req = 0;
    md_base = md_data;
    cmd_code = c;
    cmd_lba = a;
    cmd_count = n;
    cmd_feat = f;
    cmd_start = 1;
    @(negedge sys_clk);
    cmd_start = 0;
    `CHK("host busy", 1'b0, cmd_ready)
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge sys_clk);
    if (done !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    st = done_status;
    er = done_error;
    dl = done_lba;
    repeat (3) @(negedge sys_clk);
    `CHK("irq count", 1, n_irq)
    `CHK("host ready", 1'b1, cmd_ready)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_dma();
    run(EDR_CMD_DMA_EXT, 48'hA1B2_C3D4_E5F6, 16'h0101, 16'h0000);
    `CHK("dma lba", 48'hA1B2_C3D4_E5F6, fa)
    `CHK("dma words", 257 * WPS, n_rx)
    `CHK("dma status", EDR_ST_RESET, st)
    `CHK("dma kind", 1'b0, flog)
    $display("test dma done");
  endtask
  task automatic t_err();
    @(negedge sys_clk);
    err_at = md_data + 16'(WPS);
    run(EDR_CMD_DMA_EXT, 48'h0000_1000_00FF, 16'h0003, 16'h0000);
    err_at = 16'hFFFF;
    `CHK("err stat", 1'b1, st[EDR_ST_ERR])
    `CHK("err unc", 1'b1, er[EDR_ER_UNC])
    `CHK("err lba", 48'h0000_1000_0100, dl)
    `CHK("err words", WPS, n_rx)
    $display("test dma error done");
  endtask
  task automatic t_logs();
    logic [7:0] la [9] = '{8'h00, 8'h03, 8'h07, 8'h09, 8'h23, 8'h01, 8'h02, 8'h06, 8'h10};
    for (int i = 0; i < 9; i++) begin
      run(EDR_CMD_LOG_EXT, {16'h0000, 8'h5A, 16'h0000, la[i]}, 16'h0001, 16'h0000);
      `CHK("log abort", i > 4, er[EDR_ER_ABRT])
      if (i < 5) begin
        `CHK("log words", WPS, n_rx)
        `CHK("log addr", la[i], fl)
        `CHK("log kind", 1'b1, flog)
      end
    end
    $display("test log map done");
  endtask
  task automatic t_offset();
    run(EDR_CMD_LOG_EXT, 48'h0000_0000_3F03, 16'h0002, 16'h0000);
    `CHK("off abort", 1'b0, er[EDR_ER_ABRT])
    `CHK("off first", 16'h003F, fa[15:0])
    `CHK("off words", 2 * WPS, n_rx)
    $display("test offset done");
  endtask
  task automatic t_bad();
    logic [7:0] bc [6] = '{8'h2F, 8'h2F, 8'h2F, 8'h2F, 8'h2F, 8'hEC};
    logic [47:0] bl [6] = '{48'h0, 48'h0, 48'h0100_0000_0000, 48'h0001_0000_0003,
                            48'h0, 48'h0};
    logic [15:0] bn [6] = '{16'h1, 16'h0, 16'h1, 16'h1, 16'h1, 16'h1};
    logic [15:0] bf [6] = '{16'h0100, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    for (int i = 0; i < 6; i++) begin
      if (i == 4) bl[i] = 48'h0000_0000_0003;
      smart_en = (i != 4);
      run(bc[i], bl[i], bn[i], bf[i]);
      `CHK("bad abort", 1'b1, er[EDR_ER_ABRT])
      `CHK("bad words", 0, n_rx)
    end
    smart_en = 1;
    $display("test refusals done");
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    nrst = 1;
    @(negedge sys_clk);
    t_dma();
    t_err();
    t_logs();
    t_offset();
    t_bad();
    end_of_test();
  end
endmodule
